// ---- hw/fbwp_pkg.sv ----
// Shared constants, types and decode helpers for the flash block write-protect logic.
package fbwp_pkg;

  localparam int unsigned ADDR_W = 24;
  localparam int unsigned BLK_LSB = 16;
  localparam int unsigned BLK_W = 3;

  // Register byte offsets on the APB port.
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_COMMAND = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_ADDR = 8'h0c;
  localparam logic [7:0] REG_RESULT = 8'h10;
  localparam logic [7:0] REG_QUAD = 8'h14;
  localparam logic [7:0] REG_PROTECT = 8'h18;

  // Status register field positions.
  localparam int unsigned SR_BUSY_BIT = 0;
  localparam int unsigned SR_WEL_BIT = 1;
  localparam int unsigned SR_BP_LSB = 2;
  localparam int unsigned SR_QE_BIT = 6;
  localparam int unsigned SR_STATUS_WRITE_DISABLE_BIT = 7;

  // Result register bit positions.
  localparam int unsigned RES_OK = 0;
  localparam int unsigned RES_NOWEL = 1;
  localparam int unsigned RES_PROT = 2;
  localparam int unsigned RES_LOCK = 3;

  typedef enum logic [2:0] {
    DEN_4M = 3'h0, DEN_2M = 3'h1, DEN_1M = 3'h2, DEN_512K = 3'h3, DEN_256K = 3'h4
  } fbwp_density_t;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_WREN = 4'h1, CMD_WRDI = 4'h2, CMD_WSTAT = 4'h3, CMD_PROG = 4'h4,
    CMD_ERASE4K = 4'h5, CMD_ERASE32K = 4'h6, CMD_ERASE64K = 4'h7, CMD_CHIP = 4'h8
  } fbwp_cmd_t;

  typedef enum logic [2:0] {
    SZ_PAGE = 3'h0, SZ_4K = 3'h1, SZ_32K = 3'h2, SZ_64K = 3'h3, SZ_CHIP = 3'h4
  } fbwp_size_t;

  typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_CHECK = 3'h2, ST_ISSUE = 3'h4} fbwp_state_t;

  typedef struct packed {
    logic any;
    logic [BLK_W-1:0] hi;
    logic [BLK_W-1:0] lo;
  } fbwp_range_t;

  // Number of 64 KB blocks in the array; the two smallest parts count as one.
  function automatic logic [3:0] fbwp_nblk(input fbwp_density_t d);
    case (d)
      DEN_4M: return 4'h8;
      DEN_2M: return 4'h4;
      DEN_1M: return 4'h2;
      default: return 4'h1;
    endcase
  endfunction : fbwp_nblk

endpackage : fbwp_pkg

// ---- hw/fbwp_sync2.sv ----
// Two-stage synchroniser for asynchronous pin levels.
`timescale 1ns/1ps
module fbwp_sync2 import fbwp_pkg::*; #(
  parameter int unsigned W = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule : fbwp_sync2

// ---- hw/fbwp_range_dec.sv ----
// Decoder from the block-protect code to the protected block range.
`timescale 1ns/1ps
module fbwp_range_dec import fbwp_pkg::*; #(
  parameter fbwp_density_t DENSITY = DEN_4M,
  parameter bit ALT_MAP = 1'b0
) (
  input wire logic [3:0] bp,
  output fbwp_range_t rng
);

  function automatic fbwp_range_t mk(input logic [3:0] nblk, input logic top, input logic [3:0] cnt);
    fbwp_range_t r;
    logic [3:0] t;
    t = top ? 4'(nblk - cnt) : 4'h0;
    r.any = (cnt != 4'h0);
    r.lo = t[BLK_W-1:0];
    r.hi = top ? 3'(nblk - 4'h1) : 3'(cnt - 4'h1);
    return r;
  endfunction : mk

  logic top;
  logic [3:0] cnt;
  logic [3:0] nblk;

  always_comb begin
    nblk = fbwp_nblk(DENSITY);
    top = 1'b1;
    cnt = nblk;
    if (bp == 4'h0) begin
      cnt = 4'h0;
    end else if (DENSITY == DEN_4M && !ALT_MAP) begin
      case (bp)
        4'h1: cnt = 4'h1;
        4'h2: cnt = 4'h2;
        4'h3: cnt = 4'h4;
        4'h4: cnt = 4'h6;
        4'h5: cnt = 4'h7;
        4'h9: begin top = 1'b0; cnt = 4'h1; end
        4'ha: begin top = 1'b0; cnt = 4'h2; end
        4'hb: begin top = 1'b0; cnt = 4'h4; end
        4'hc: begin top = 1'b0; cnt = 4'h6; end
        4'hd: begin top = 1'b0; cnt = 4'h7; end
        default: cnt = nblk;
      endcase
    end else if (DENSITY == DEN_4M) begin
      case (bp)
        4'h1: cnt = 4'h1;
        4'h2: cnt = 4'h2;
        4'h3: cnt = 4'h4;
        4'h4: cnt = 4'h6;
        4'h5: cnt = 4'h7;
        4'ha: begin top = 1'b0; cnt = 4'h7; end
        4'hb: begin top = 1'b0; cnt = 4'h6; end
        4'hc: begin top = 1'b0; cnt = 4'h4; end
        4'hd: begin top = 1'b0; cnt = 4'h2; end
        4'he: begin top = 1'b0; cnt = 4'h1; end
        4'hf: cnt = 4'h0;
        default: cnt = nblk;
      endcase
    end else if (DENSITY == DEN_2M) begin
      case (bp)
        4'h1: cnt = 4'h1;
        4'h2: cnt = 4'h2;
        4'h3: cnt = 4'h3;
        4'h9: begin top = ALT_MAP; cnt = ALT_MAP ? nblk : 4'h1; end
        4'ha: begin top = ALT_MAP; cnt = ALT_MAP ? nblk : 4'h2; end
        4'hb: begin top = ALT_MAP; cnt = ALT_MAP ? nblk : 4'h3; end
        4'hc: begin top = !ALT_MAP; cnt = ALT_MAP ? 4'h3 : nblk; end
        4'hd: begin top = !ALT_MAP; cnt = ALT_MAP ? 4'h2 : nblk; end
        4'he: begin top = !ALT_MAP; cnt = ALT_MAP ? 4'h1 : nblk; end
        4'hf: cnt = ALT_MAP ? 4'h0 : nblk;
        default: cnt = nblk;
      endcase
    end else if (DENSITY == DEN_1M) begin
      case (bp)
        4'h1: cnt = 4'h1;
        4'h9: begin top = ALT_MAP; cnt = ALT_MAP ? nblk : 4'h1; end
        4'he: begin top = !ALT_MAP; cnt = ALT_MAP ? 4'h1 : nblk; end
        4'hf: cnt = ALT_MAP ? 4'h0 : nblk;
        default: cnt = nblk;
      endcase
    end else begin
      cnt = (ALT_MAP && bp == 4'hf) ? 4'h0 : nblk;
    end
    rng = mk(nblk, top, cnt);
  end

endmodule : fbwp_range_dec

// ---- hw/fbwp_top.sv ----
// Block write-protect and status-register lock logic behind an APB register port.
`timescale 1ns/1ps
module fbwp_top import fbwp_pkg::*; #(
  parameter fbwp_density_t DENSITY = DEN_4M,
  parameter bit ALT_MAP = 1'b0,
  parameter bit OPT_C = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic io2_in,
  input wire logic io3_in,
  output logic quad_data_line_two,
  output logic io2_oe_n,
  output logic quad_data_line_three,
  output logic io3_oe_n,
  output logic hold_active,
  output logic op_start,
  output fbwp_cmd_t op_cmd,
  output fbwp_size_t op_size,
  output logic [ADDR_W-1:0] op_addr
);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.

  if (OPT_C && DENSITY != DEN_1M) begin : g_bad_optc
    $error("The 32 KB erase variant exists only at 1 Mb density.");
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    fbwp_state_t state;
    logic write_enable_latch;
    logic [3:0] bp;
    logic quad_enable;
    logic status_write_disable;
    fbwp_cmd_t cmd;
    logic [7:0] wdata;
    logic [ADDR_W-1:0] addr;
    logic [3:0] result;
    logic hit;
    logic [1:0] qdrive;
    logic qdrive_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic io2_oe_n;
    logic io3_oe_n;
    logic hold;
    logic op_start;
    fbwp_cmd_t op_cmd;
    fbwp_size_t op_size;
    logic [ADDR_W-1:0] op_addr;
  } fbwp_st_t;

  fbwp_st_t st_ff;
  fbwp_st_t nxt_st;
  fbwp_range_t rng;
  logic [1:0] pin_sync;
  logic wp_level;
  logic needs_wel;
  logic [BLK_W-1:0] blk;
  logic apb_wr;

  fbwp_sync2 #(.W(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({io3_in, io2_in}),
    .dout(pin_sync)
  );

  fbwp_range_dec #(.DENSITY(DENSITY), .ALT_MAP(ALT_MAP)) u_dec (
    .bp(st_ff.bp),
    .rng(rng)
  );

  function automatic logic mapped(input logic [7:0] a);
    return a == REG_STATUS || a == REG_COMMAND || a == REG_WDATA || a == REG_ADDR ||
           a == REG_RESULT || a == REG_QUAD || a == REG_PROTECT;
  endfunction : mapped

  function automatic logic is_write_op(input fbwp_cmd_t c);
    return c == CMD_WSTAT || c == CMD_PROG || c == CMD_ERASE4K || c == CMD_ERASE32K ||
           c == CMD_ERASE64K || c == CMD_CHIP;
  endfunction : is_write_op

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // With quad-enable set the pin no longer protects, so the status bits act as if it were high.
  assign wp_level = st_ff.quad_enable ? 1'b1 : pin_sync[0];
  assign needs_wel = is_write_op(st_ff.cmd);
  assign blk = st_ff.addr[BLK_LSB +: BLK_W] & 3'(fbwp_nblk(DENSITY) - 4'h1);
  assign apb_wr = psel && penable && pwrite && st_ff.pready && !st_ff.pslverr;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.op_start = 1'b0;
    nxt_st.pready = psel && !penable;
    nxt_st.pslverr = psel && !penable && !mapped(paddr);
    nxt_st.hold = !st_ff.quad_enable && !pin_sync[1];
    nxt_st.io2_oe_n = !(st_ff.quad_enable && st_ff.qdrive_en);
    nxt_st.io3_oe_n = !(st_ff.quad_enable && st_ff.qdrive_en);
    if (psel && !penable) begin
      nxt_st.prdata = 32'h0;
      case (paddr)
        REG_STATUS: begin
          nxt_st.prdata[SR_BUSY_BIT] = st_ff.state != ST_IDLE;
          nxt_st.prdata[SR_WEL_BIT] = st_ff.write_enable_latch;
          nxt_st.prdata[SR_BP_LSB +: 4] = st_ff.bp;
          nxt_st.prdata[SR_QE_BIT] = st_ff.quad_enable;
          nxt_st.prdata[SR_STATUS_WRITE_DISABLE_BIT] = st_ff.status_write_disable;
        end
        REG_COMMAND: nxt_st.prdata[3:0] = st_ff.cmd;
        REG_WDATA: nxt_st.prdata[7:0] = st_ff.wdata;
        REG_ADDR: nxt_st.prdata[ADDR_W-1:0] = st_ff.addr;
        REG_RESULT: nxt_st.prdata[3:0] = st_ff.result;
        REG_QUAD: nxt_st.prdata[4:0] = {pin_sync, st_ff.qdrive_en, st_ff.qdrive};
        REG_PROTECT: nxt_st.prdata[6:0] = rng;
        default: nxt_st.prdata = 32'h0;
      endcase
    end
    if (apb_wr) begin
      case (paddr)
        REG_COMMAND: begin
          // A command written while one is still being checked is dropped.
          if (st_ff.state == ST_IDLE) begin
            nxt_st.cmd = fbwp_cmd_t'(pwdata[3:0]);
            nxt_st.state = ST_CHECK;
          end
        end
        REG_WDATA: nxt_st.wdata = pwdata[7:0];
        REG_ADDR: nxt_st.addr = pwdata[ADDR_W-1:0];
        REG_QUAD: begin
          nxt_st.qdrive = pwdata[1:0];
          nxt_st.qdrive_en = pwdata[2];
        end
        default: nxt_st.qdrive = st_ff.qdrive;
      endcase
    end
    case (st_ff.state)
      ST_IDLE: nxt_st.hit = 1'b0;
      ST_CHECK: begin
        nxt_st.state = ST_IDLE;
        nxt_st.result = 4'h0;
        if (st_ff.cmd == CMD_WREN) begin
          nxt_st.write_enable_latch = 1'b1;
          nxt_st.result[RES_OK] = 1'b1;
        end else if (st_ff.cmd == CMD_WRDI) begin
          nxt_st.write_enable_latch = 1'b0;
          nxt_st.result[RES_OK] = 1'b1;
        end else if (needs_wel && !st_ff.write_enable_latch) begin
          nxt_st.result[RES_NOWEL] = 1'b1;
        end else if (st_ff.cmd == CMD_WSTAT) begin
          if (st_ff.status_write_disable && !wp_level) begin
            nxt_st.result[RES_LOCK] = 1'b1;
          end else begin
            nxt_st.bp = st_ff.wdata[SR_BP_LSB +: 4];
            nxt_st.quad_enable = st_ff.wdata[SR_QE_BIT];
            nxt_st.status_write_disable = st_ff.wdata[SR_STATUS_WRITE_DISABLE_BIT];
            nxt_st.write_enable_latch = 1'b0;
            nxt_st.result[RES_OK] = 1'b1;
          end
        end else if (needs_wel) begin
          // Chip erase touches every block, so any protection at all blocks it.
          nxt_st.hit = (st_ff.cmd == CMD_CHIP) ? rng.any :
                       (rng.any && blk >= rng.lo && blk <= rng.hi);
          nxt_st.state = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        nxt_st.state = ST_IDLE;
        if (st_ff.hit) begin
          nxt_st.result[RES_PROT] = 1'b1;
        end else begin
          nxt_st.result[RES_OK] = 1'b1;
          nxt_st.write_enable_latch = 1'b0;
          nxt_st.op_start = 1'b1;
          nxt_st.op_cmd = st_ff.cmd;
          nxt_st.op_addr = st_ff.addr;
          case (st_ff.cmd)
            CMD_PROG: nxt_st.op_size = SZ_PAGE;
            CMD_ERASE4K: nxt_st.op_size = SZ_4K;
            CMD_ERASE32K: nxt_st.op_size = SZ_32K;
            CMD_ERASE64K: nxt_st.op_size = OPT_C ? SZ_32K : SZ_64K;
            default: nxt_st.op_size = SZ_CHIP;
          endcase
        end
      end
      default: nxt_st.state = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Registers and outputs.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{state: ST_IDLE, cmd: CMD_NONE, op_cmd: CMD_NONE, op_size: SZ_PAGE,
                 io2_oe_n: 1'b1, io3_oe_n: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign quad_data_line_two = st_ff.qdrive[0];
  assign quad_data_line_three = st_ff.qdrive[1];
  assign io2_oe_n = st_ff.io2_oe_n;
  assign io3_oe_n = st_ff.io3_oe_n;
  assign hold_active = st_ff.hold;
  assign op_start = st_ff.op_start;
  assign op_cmd = st_ff.op_cmd;
  assign op_size = st_ff.op_size;
  assign op_addr = st_ff.op_addr;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_hit_issue;
    st_ff.state == ST_ISSUE && st_ff.hit;
  endsequence

  sequence s_no_start_2;
    !op_start ##1 !op_start;
  endsequence

  property p_reject_protected;
    s_hit_issue |=> !op_start && st_ff.result[RES_PROT] && st_ff.state == ST_IDLE;
  endproperty
  a_reject_protected: assert property (p_reject_protected) else $error("Protected op was started.");

  property p_zero_none;
    st_ff.bp == 4'h0 |-> !rng.any;
  endproperty
  a_zero_none: assert property (p_zero_none) else $error("Code zero protects blocks.");

  property p_4m_top;
    (DENSITY == DEN_4M && !ALT_MAP && st_ff.bp == 4'h4) |-> rng.any && rng.lo == 3'h2 && rng.hi == 3'h7;
  endproperty
  a_4m_top: assert property (p_4m_top) else $error("Code 4 range wrong at 4 Mb.");

  property p_4m_all;
    (DENSITY == DEN_4M && !ALT_MAP && st_ff.bp inside {4'h6, 4'h7, 4'h8, 4'he, 4'hf})
      |-> rng.any && rng.lo == 3'h0 && rng.hi == 3'h7;
  endproperty
  a_4m_all: assert property (p_4m_all) else $error("Whole-array code range wrong at 4 Mb.");

  property p_4m_bottom;
    (DENSITY == DEN_4M && !ALT_MAP && st_ff.bp == 4'hc) |-> rng.any && rng.lo == 3'h0 && rng.hi == 3'h5;
  endproperty
  a_4m_bottom: assert property (p_4m_bottom) else $error("Code 12 range wrong at 4 Mb.");

  property p_2m_map;
    (DENSITY == DEN_2M && !ALT_MAP && st_ff.bp == 4'hb) |-> rng.lo == 3'h0 && rng.hi == 3'h2;
  endproperty
  a_2m_map: assert property (p_2m_map) else $error("Code 11 range wrong at 2 Mb.");

  property p_alt_none;
    (DENSITY == DEN_4M && ALT_MAP && st_ff.bp == 4'hf) |-> !rng.any;
  endproperty
  a_alt_none: assert property (p_alt_none) else $error("Alternate code 15 protects blocks.");

  property p_status_locked;
    (st_ff.state == ST_CHECK && st_ff.cmd == CMD_WSTAT && st_ff.write_enable_latch &&
     st_ff.status_write_disable && !wp_level)
      |=> $stable(st_ff.bp) && $stable(st_ff.quad_enable) && st_ff.status_write_disable;
  endproperty
  a_status_locked: assert property (p_status_locked) else $error("Locked status bits changed.");

  property p_status_free;
    (st_ff.state == ST_CHECK && st_ff.cmd == CMD_WSTAT && st_ff.write_enable_latch &&
     !st_ff.status_write_disable) |=> st_ff.bp == $past(st_ff.wdata[SR_BP_LSB +: 4]) && !st_ff.write_enable_latch;
  endproperty
  a_status_free: assert property (p_status_free) else $error("Status write not taken.");

  property p_need_wel;
    (st_ff.state == ST_CHECK && needs_wel && !st_ff.write_enable_latch) |=> s_no_start_2;
  endproperty
  a_need_wel: assert property (p_need_wel) else $error("Op started without write enable.");

  property p_pins_inputs;
    !st_ff.quad_enable |=> io2_oe_n && io3_oe_n;
  endproperty
  a_pins_inputs: assert property (p_pins_inputs) else $error("Shared pins driven with quad off.");

  property p_pins_quad;
    (st_ff.quad_enable && st_ff.qdrive_en) |=> !io2_oe_n && !io3_oe_n;
  endproperty
  a_pins_quad: assert property (p_pins_quad) else $error("Quad lines not driven.");

  property p_optc_erase;
    (OPT_C && op_start && op_cmd == CMD_ERASE64K) |-> op_size == SZ_32K;
  endproperty
  a_optc_erase: assert property (p_optc_erase) else $error("Large erase on 32 KB variant.");

endmodule : fbwp_top

// ---- tb/fbwp_host_pins.sv ----
// Far-side model: the host's levels on the shared protect and hold pins.
`timescale 1ns/1ps
module fbwp_host_pins (
  input wire logic wp_lvl,
  input wire logic hold_lvl,
  input wire logic quad_data_line_two,
  input wire logic io2_oe_n,
  input wire logic quad_data_line_three,
  input wire logic io3_oe_n,
  output logic io2_in,
  output logic io3_in
);
  // The host lets go of a pin while the device drives it, and it never ties a pin to supply.
  assign io2_in = io2_oe_n ? wp_lvl : quad_data_line_two;
  assign io3_in = io3_oe_n ? hold_lvl : quad_data_line_three;
endmodule : fbwp_host_pins

// ---- tb/tb_top.sv ----
// Self-checking testbench for the block write-protect logic.
`timescale 1ns/1ps
module tb_top import fbwp_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, wp_lvl, hold_lvl, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, res, rd_alt, rd_2m, rd_1m, qa, q2, q1;
  logic pready, pslverr, io2_in, io3_in, l2, oe2, l3, oe3, hold_active, op_start;
  fbwp_cmd_t op_cmd;
  fbwp_size_t op_size, size_1m;
  logic [ADDR_W-1:0] op_addr, seen_addr;
  int failures, n_tests, n_starts, k;
  // Expected ranges, indexed by the protect code; the 4 Mb maps share their low ends.
  localparam logic [2:0] LO4[16] = '{3'h0, 3'h7, 3'h6, 3'h4, 3'h2, 3'h1, 3'h0, 3'h0,
    3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  localparam logic [2:0] HI4[16] = '{3'h0, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7,
    3'h7, 3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7, 3'h7};
  localparam logic [2:0] HIA[16] = '{3'h0, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7,
    3'h7, 3'h7, 3'h6, 3'h5, 3'h3, 3'h1, 3'h0, 3'h0};
  localparam logic [2:0] LO2[16] = '{3'h0, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0,
    3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  localparam logic [2:0] HI2[16] = '{3'h0, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3,
    3'h3, 3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3};

  fbwp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io2_in(io2_in), .io3_in(io3_in), .quad_data_line_two(l2), .io2_oe_n(oe2),
    .quad_data_line_three(l3), .io3_oe_n(oe3), .hold_active(hold_active), .op_start(op_start),
    .op_cmd(op_cmd), .op_size(op_size), .op_addr(op_addr));
  fbwp_host_pins pins (.wp_lvl(wp_lvl), .hold_lvl(hold_lvl), .quad_data_line_two(l2), .io2_oe_n(oe2),
    .quad_data_line_three(l3), .io3_oe_n(oe3), .io2_in(io2_in), .io3_in(io3_in));
  // Other maps and densities listen on the same bus; only their read data and the 1 Mb part's erase size are watched.
  fbwp_top #(.DENSITY(DEN_4M), .ALT_MAP(1'b1)) dut_alt (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(rd_alt), .pready(), .pslverr(),
    .io2_in(io2_in), .io3_in(io3_in), .quad_data_line_two(), .io2_oe_n(), .quad_data_line_three(), .io3_oe_n(),
    .hold_active(), .op_start(), .op_cmd(), .op_size(), .op_addr());
  fbwp_top #(.DENSITY(DEN_2M)) dut_2m (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(rd_2m), .pready(), .pslverr(),
    .io2_in(io2_in), .io3_in(io3_in), .quad_data_line_two(), .io2_oe_n(), .quad_data_line_three(), .io3_oe_n(),
    .hold_active(), .op_start(), .op_cmd(), .op_size(), .op_addr());
  fbwp_top #(.DENSITY(DEN_1M), .OPT_C(1'b1)) dut_1m (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(rd_1m), .pready(), .pslverr(),
    .io2_in(io2_in), .io3_in(io3_in), .quad_data_line_two(), .io2_oe_n(), .quad_data_line_three(), .io3_oe_n(),
    .hold_active(), .op_start(), .op_cmd(), .op_size(size_1m), .op_addr());

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Sampled mid-cycle so the one-cycle start pulse is never missed or raced.
  always @(negedge pclk) begin
    if (op_start === 1'b1) begin
      n_starts++;
      seen_addr = op_addr;
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // The request stands until the rising edge at which ready is seen; the answer is taken at that edge.
  // One idle edge leads each transfer, so a release and the next setup never meet in one time step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    qa = rd_alt;
    q2 = rd_2m;
    q1 = rd_1m;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cmd(input fbwp_cmd_t c);
    int n;
    n = 0;
    apb(1'b1, REG_COMMAND, {28'h0, c});
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (q[SR_BUSY_BIT] !== 1'b0 && n < 8);
    chk("busy", 32'h0, {31'h0, q[SR_BUSY_BIT]});
    apb(1'b0, REG_RESULT, 32'h0);
    res = q;
  endtask : cmd

  task automatic wstat(input logic [7:0] v);
    apb(1'b1, REG_WDATA, {24'h0, v});
    cmd(CMD_WREN);
    cmd(CMD_WSTAT);
  endtask : wstat

  task automatic op(input fbwp_cmd_t c, input logic [23:0] a);
    apb(1'b1, REG_ADDR, {8'h0, a});
    cmd(CMD_WREN);
    cmd(c);
  endtask : op

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h0, q);
    apb(1'b0, REG_PROTECT, 32'h0);
    chk("prot any", 32'h0, {31'h0, q[6]});
    apb(1'b0, 8'hfc, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    k = n_starts;
    apb(1'b1, REG_ADDR, 32'h0);
    cmd(CMD_PROG);
    chk("no latch", 32'h1 << RES_NOWEL, res);
    chk("starts", k, n_starts);
    $display("test reset done");
  endtask : t_reset

  task automatic t_table();
    for (int c = 0; c < 16; c++) begin
      wstat({2'b00, c[3:0], 2'b00});
      chk("wstat", 32'h1 << RES_OK, res);
      apb(1'b0, REG_STATUS, 32'h0);
      chk("status", {26'h0, c[3:0], 2'b00}, q);
      apb(1'b0, REG_PROTECT, 32'h0);
      if (c == 0) chk("prot", 32'h0, {31'h0, q[6]});
      else chk("prot", {25'h0, 1'b1, HI4[c], LO4[c]}, q);
      if (c == 0 || c == 15) chk("prot alt", 32'h0, {31'h0, qa[6]});
      else chk("prot alt", {25'h0, 1'b1, HIA[c], LO4[c]}, qa);
      if (c != 0) chk("prot 2m", {25'h0, 1'b1, HI2[c], LO2[c]}, q2);
      if (c != 0) chk("prot 1m", {25'h0, 1'b1, (c == 9) ? 3'h0 : 3'h1, (c == 1) ? 3'h1 : 3'h0}, q1);
    end
    $display("test table done");
  endtask : t_table

  task automatic t_block();
    wstat(8'h04);
    k = n_starts;
    for (int c = CMD_PROG; c <= CMD_CHIP; c++) begin
      op(fbwp_cmd_t'(c), 24'h07fff0);
      chk("refused", 32'h1 << RES_PROT, res);
    end
    chk("starts", k, n_starts);
    op(CMD_ERASE64K, 24'h06ff00);
    chk("accepted", 32'h1 << RES_OK, res);
    chk("starts", k + 1, n_starts);
    chk("op addr", 32'h0006ff00, {8'h0, seen_addr});
    chk("op cmd", {28'h0, CMD_ERASE64K}, {28'h0, op_cmd});
    chk("op size", {29'h0, SZ_64K}, {29'h0, op_size});
    chk("1m size", {29'h0, SZ_32K}, {29'h0, size_1m});
    wstat(8'h24);
    op(CMD_PROG, 24'h00ffff);
    chk("bottom", 32'h1 << RES_PROT, res);
    op(CMD_PROG, 24'h010000);
    chk("above", 32'h1 << RES_OK, res);
    wstat(8'h00);
    $display("test block done");
  endtask : t_block

  task automatic t_lock();
    wstat(8'ha4);
    chk("lock set", 32'h1 << RES_OK, res);
    wstat(8'h00);
    chk("locked", 32'h1 << RES_LOCK, res);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("frozen", 32'ha6, q);
    wp_lvl <= 1'b1;
    repeat (4) @(posedge pclk);
    wstat(8'h00);
    chk("pin high", 32'h1 << RES_OK, res);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("cleared", 32'h0, q);
    wp_lvl <= 1'b0;
    $display("test lock done");
  endtask : t_lock

  task automatic t_quad();
    hold_lvl <= 1'b0;
    repeat (5) @(posedge pclk);
    @(negedge pclk);
    chk("hold", 32'h1, {31'h0, hold_active});
    @(posedge pclk);
    hold_lvl <= 1'b1;
    wstat(8'h40);
    apb(1'b1, REG_QUAD, 32'h5);
    hold_lvl <= 1'b0;
    repeat (5) @(posedge pclk);
    @(negedge pclk);
    chk("quad pins", 32'h2, {28'h0, oe2, oe3, l2, l3});
    chk("no hold", 32'h0, {31'h0, hold_active});
    @(posedge pclk);
    apb(1'b0, REG_QUAD, 32'h0);
    chk("quad lines", 32'h1, {30'h0, q[4:3]});
    apb(1'b1, REG_QUAD, 32'h0);
    hold_lvl <= 1'b1;
    wstat(8'h00);
    $display("test quad done");
  endtask : t_quad

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, wp_lvl} = 5'h0;
    hold_lvl = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_table();
    t_block();
    t_lock();
    t_quad();
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    $display("ERROR watchdog expected done seen timeout");
    finish_test();
  end
endmodule : tb_top
